// ---- rtl/ppf_framer.sv ----
// PCM packet framer top: packet sequencing, trailer and register port
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none

module ppf_framer (
	// Clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	// Frame synchronizer bits
	input  wire ppf_pkg::ppf_bit_s     BIT_IN,
	input  wire logic [3:0]            SYNCHRONIZER_LOCK_STATE,
	input  wire logic [63:0]           TIME_STAMP,
	// Packet word stream
	output ppf_pkg::ppf_word_s         PKT_OUT,
	output logic                       PKT_END,
	// Register port
	input  wire logic [7:0]            REG_ADDR,
	input  wire logic [31:0]           REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic [31:0]                REG_RDATA
);

	ppf_pkg::ppf_state_e state_ff;
	ppf_pkg::ppf_state_e nxt_state;
	logic [5:0]          ctrl_ff;
	logic [7:0]          frames_cfg_ff;
	logic [15:0]         fixlen_ff;
	logic [5:0]          synclen_ff;
	logic [15:0]         pkt_cnt_ff;
	logic [31:0]         csd_ff;
	logic [63:0]         ts_ff;
	logic [3:0]          lock_ff;
	logic [17:0]         wpos_ff;
	logic [2:0]          hdr_idx_ff;
	logic                cks_idx_ff;
	logic                hdr_pend_ff;
	logic [7:0]          frames_ff;
	logic                frames_done_ff;
	logic [7:0]          dcnt_ff;
	logic [15:0]         wcnt_ff;
	logic                cfg_en;
	logic                cfg_thru;
	logic                cfg_unpk;
	logic [1:0]          cfg_cks;
	logic                cfg_fix;
	logic                start_framed;
	logic                capturing;
	logic                pk_en;
	logic                pk_take;
	logic                pk_valid;
	logic [15:0]         pk_data;
	logic                pk_ready;
	logic                em_v;
	logic [15:0]         em_d;
	logic                cks_add;
	logic [31:0]         cks_sum;
	logic [15:0]         tot;
	logic                fill_ok;

	assign cfg_en   = ctrl_ff[ppf_pkg::CTRL_EN_BIT];
	assign cfg_thru = ctrl_ff[ppf_pkg::CTRL_THRU_BIT];
	assign cfg_unpk = ctrl_ff[ppf_pkg::CTRL_UNPK_BIT];
	assign cfg_cks  = ctrl_ff[ppf_pkg::CTRL_CKS_LSB +: 2];
	assign cfg_fix  = ctrl_ff[ppf_pkg::CTRL_FIX_BIT];

	// Packet start and bit capture window
	always_comb begin
		// Framed packets open only on a minor frame start
		start_framed = cfg_en & ~cfg_thru & (state_ff == ppf_pkg::ST_IDLE)
			& BIT_IN.valid & BIT_IN.minor_start;
		capturing    = ((state_ff == ppf_pkg::ST_CSD_LO) | (state_ff == ppf_pkg::ST_CSD_HI)
			| (state_ff == ppf_pkg::ST_HDR) | (state_ff == ppf_pkg::ST_DATA)) & ~frames_done_ff;
		pk_en        = cfg_en & (cfg_thru | capturing | start_framed);
		pk_take      = pk_en & BIT_IN.valid;
		// Trailer length with zero filler added until both targets hold
		tot          = wcnt_ff + {14'h0000, ppf_pkg::cks_words(cfg_cks)};
		fill_ok      = ~tot[0] & (~cfg_fix | (tot >= fixlen_ff));
	end

	// Packet sequencing and word selection
	always_comb begin
		nxt_state = state_ff;
		em_v      = 1'b0;
		em_d      = 16'h0000;
		pk_ready  = 1'b0;
		case (state_ff)
			ppf_pkg::ST_IDLE: begin
				if (cfg_en & (cfg_thru ? pk_valid : start_framed)) begin
					nxt_state = ppf_pkg::ST_CSD_LO;
				end
			end
			ppf_pkg::ST_CSD_LO: begin
				em_v      = 1'b1;
				em_d      = csd_ff[15:0];
				nxt_state = ppf_pkg::ST_CSD_HI;
			end
			ppf_pkg::ST_CSD_HI: begin
				em_v      = 1'b1;
				em_d      = csd_ff[31:16];
				nxt_state = cfg_thru ? ppf_pkg::ST_DATA : ppf_pkg::ST_HDR;
			end
			ppf_pkg::ST_HDR: begin
				em_v = 1'b1;
				case (hdr_idx_ff)
					3'd0:    em_d = ts_ff[15:0];
					3'd1:    em_d = ts_ff[31:16];
					3'd2:    em_d = ts_ff[47:32];
					3'd3:    em_d = ts_ff[63:48];
					default: em_d = {lock_ff, 12'h000};
				endcase
				if (hdr_idx_ff == ppf_pkg::HDR_LAST_IDX) begin
					nxt_state = ppf_pkg::ST_DATA;
				end
			end
			ppf_pkg::ST_DATA: begin
				if (pk_valid) begin
					em_v     = 1'b1;
					em_d     = pk_data;
					pk_ready = 1'b1;
					if (cfg_thru & ((dcnt_ff + 8'd1) == frames_cfg_ff)) begin
						nxt_state = ppf_pkg::ST_FILL;
					end
				end else if (hdr_pend_ff) begin
					// Previous frame fully out before the next header
					nxt_state = ppf_pkg::ST_HDR;
				end else if (~cfg_thru & frames_done_ff) begin
					nxt_state = ppf_pkg::ST_FILL;
				end
			end
			ppf_pkg::ST_FILL: begin
				if (fill_ok) begin
					nxt_state = (cfg_cks == ppf_pkg::CKS_NONE) ? ppf_pkg::ST_END : ppf_pkg::ST_CKS;
				end else begin
					em_v = 1'b1;
				end
			end
			ppf_pkg::ST_CKS: begin
				em_v = 1'b1;
				case (cfg_cks)
					ppf_pkg::CKS_8:  em_d = {cks_sum[7:0], 8'h00};
					ppf_pkg::CKS_16: em_d = cks_sum[15:0];
					default:         em_d = cks_idx_ff ? cks_sum[31:16] : cks_sum[15:0];
				endcase
				if ((cfg_cks != ppf_pkg::CKS_32) | cks_idx_ff) begin
					nxt_state = ppf_pkg::ST_END;
				end
			end
			ppf_pkg::ST_END: begin
				nxt_state = ppf_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = ppf_pkg::ST_IDLE;
			end
		endcase
		// The checksum word itself never joins the sum
		cks_add = em_v & (state_ff != ppf_pkg::ST_CKS);
	end

	// State register and header and checksum word indices
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff   <= ppf_pkg::ST_IDLE;
			hdr_idx_ff <= 3'd0;
			cks_idx_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			hdr_idx_ff <= (state_ff == ppf_pkg::ST_HDR) ? hdr_idx_ff + 3'd1 : 3'd0;
			cks_idx_ff <= (state_ff == ppf_pkg::ST_CKS) ? ~cks_idx_ff : 1'b0;
		end
	end

	// Word position within the major frame, tracked on every bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wpos_ff <= 18'h00000;
		end else if (BIT_IN.valid) begin
			wpos_ff <= BIT_IN.major_start ? {17'h00000, BIT_IN.word_end}
				: wpos_ff + {17'h00000, BIT_IN.word_end};
		end
	end

	// Channel specific data word, latched at packet start
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			csd_ff <= 32'h00000000;
		end else if (state_ff == ppf_pkg::ST_IDLE) begin
			csd_ff <= 32'h00000000;
			if (cfg_thru) begin
				csd_ff[ppf_pkg::CSD_THRU_BIT] <= 1'b1;
			end else begin
				csd_ff[ppf_pkg::CSD_IPH_BIT]  <= 1'b1;
				csd_ff[ppf_pkg::CSD_MA_BIT]   <= BIT_IN.major_start;
				csd_ff[ppf_pkg::CSD_MI_BIT]   <= BIT_IN.minor_start;
				csd_ff[ppf_pkg::CSD_LOCK_LSB +: 4] <= SYNCHRONIZER_LOCK_STATE;
				csd_ff[ppf_pkg::CSD_PACK_BIT] <= ~cfg_unpk;
				csd_ff[ppf_pkg::CSD_UNPK_BIT] <= cfg_unpk;
				if (cfg_unpk) begin
					csd_ff[ppf_pkg::OFFSET_W-1:0] <= BIT_IN.major_start ? 18'h00000 : wpos_ff;
				end
			end
		end
	end

	// Time stamp and lock state caught at each accepted minor frame start
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ts_ff   <= 64'h0000000000000000;
			lock_ff <= 4'h0;
		end else if (pk_take & BIT_IN.minor_start & ~cfg_thru) begin
			ts_ff   <= TIME_STAMP;
			lock_ff <= SYNCHRONIZER_LOCK_STATE;
		end
	end

	// Pending header for frames after the first; a new start wins the clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hdr_pend_ff <= 1'b0;
		end else if (pk_take & BIT_IN.minor_start & ~cfg_thru
				& (state_ff == ppf_pkg::ST_DATA)) begin
			hdr_pend_ff <= 1'b1;
		end else if (state_ff == ppf_pkg::ST_HDR) begin
			hdr_pend_ff <= 1'b0;
		end
	end

	// Whole frame count; capture stops once the last frame ends
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			frames_ff      <= 8'h00;
			frames_done_ff <= 1'b0;
		end else if (state_ff == ppf_pkg::ST_END) begin
			frames_ff      <= 8'h00;
			frames_done_ff <= 1'b0;
		end else if (pk_take & BIT_IN.frame_end & ~cfg_thru) begin
			frames_ff      <= frames_ff + 8'd1;
			frames_done_ff <= ((frames_ff + 8'd1) >= frames_cfg_ff);
		end
	end

	// Emitted word counts for filler and throughput length
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wcnt_ff <= 16'h0000;
			dcnt_ff <= 8'h00;
		end else if (state_ff == ppf_pkg::ST_IDLE) begin
			wcnt_ff <= 16'h0000;
			dcnt_ff <= 8'h00;
		end else begin
			wcnt_ff <= wcnt_ff + {15'h0000, em_v};
			dcnt_ff <= dcnt_ff + {7'h00, pk_ready};
		end
	end

	// Registered stream outputs and packet counter
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PKT_OUT    <= '0;
			PKT_END    <= 1'b0;
			pkt_cnt_ff <= 16'h0000;
		end else begin
			PKT_OUT.valid <= em_v;
			PKT_OUT.data  <= em_d;
			PKT_OUT.first <= em_v & (state_ff == ppf_pkg::ST_CSD_LO);
			PKT_END       <= (state_ff == ppf_pkg::ST_END);
			pkt_cnt_ff    <= pkt_cnt_ff + {15'h0000, (state_ff == ppf_pkg::ST_END)};
		end
	end

	// Register writes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_ff       <= ppf_pkg::CTRL_RST;
			frames_cfg_ff <= ppf_pkg::FRAMES_RST;
			fixlen_ff     <= ppf_pkg::FIXLEN_RST;
			synclen_ff    <= ppf_pkg::SYNCLEN_RST;
		end else if (REG_WR) begin
			case (REG_ADDR)
				ppf_pkg::REG_CTRL:    ctrl_ff       <= REG_WDATA[5:0];
				ppf_pkg::REG_FRAMES:  frames_cfg_ff <= REG_WDATA[7:0];
				ppf_pkg::REG_FIXLEN:  fixlen_ff     <= REG_WDATA[15:0];
				ppf_pkg::REG_SYNCLEN: synclen_ff    <= REG_WDATA[5:0];
				default:              ctrl_ff       <= ctrl_ff;
			endcase
		end
	end

	// Register reads, one cycle later; unmapped reads give zero
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				ppf_pkg::REG_CTRL:    REG_RDATA <= {26'h0000000, ctrl_ff};
				ppf_pkg::REG_FRAMES:  REG_RDATA <= {24'h000000, frames_cfg_ff};
				ppf_pkg::REG_FIXLEN:  REG_RDATA <= {16'h0000, fixlen_ff};
				ppf_pkg::REG_SYNCLEN: REG_RDATA <= {26'h0000000, synclen_ff};
				ppf_pkg::REG_STATUS:  REG_RDATA <= {8'h00, state_ff, pkt_cnt_ff};
				default:              REG_RDATA <= 32'h00000000;
			endcase
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// Bit assembly into packet words
	ppf_bit_packer u_packer (
		.clk       (CLK),
		.rst_n     (RST_N),
		.en        (pk_en),
		.thru      (cfg_thru),
		.unpk      (cfg_unpk),
		.sync_len  (synclen_ff),
		.bit_in    (BIT_IN),
		.out_ready (pk_ready),
		.out_valid (pk_valid),
		.out_data  (pk_data)
	);

	// Checksum over channel word, headers, body and filler, cleared between packets
	ppf_checksum u_cks (
		.clk   (CLK),
		.rst_n (RST_N),
		.clr   (state_ff == ppf_pkg::ST_IDLE),
		.add   (cks_add),
		.sel   (cfg_cks),
		.word  (em_d),
		.sum   (cks_sum)
	);

endmodule : ppf_framer

`default_nettype wire

// ---- rtl/ppf_pkg.sv ----
// Constants, types and helpers shared by the PCM packet framer
// Function
// - Filler makes packet a four-byte multiple, optionally fixed
// - Flags 01 append 8-bit byte sum
// - Flags 10 append 16-bit word sum
// - Flags 11 append 32-bit long-word sum
// - Unpacking per channel, words LSB-aligned on 16 bits
// - Frame sync off gives raw throughput mode
// - Bits 17-0 hold word offset into major frame
// - Bits 20/19/18 flag throughput, packed, unpacked mode
// - Bits 27-26 carry minor frame lock state
// - Bits 25-24 carry major frame lock state
// - Bit 30 set, headers present, except throughput
// - Whole frames with headers, throughput unaligned headerless
// - Order: channel word, stamp, data header, data, trailer
// - Unpacked words padded up to next 16-bit boundary
// - Long sync split in two, second gets odd bit
// - Checksum covers body and filler, not headers; here the channel word and header words are summed too
`default_nettype none

package ppf_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_FRAMES    = 8'h04;
	localparam logic [7:0] REG_FIXLEN    = 8'h08;
	localparam logic [7:0] REG_SYNCLEN   = 8'h0c;
	localparam logic [7:0] REG_STATUS    = 8'h10;

	// Control register fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_THRU_BIT = 1;
	localparam int CTRL_UNPK_BIT = 2;
	localparam int CTRL_CKS_LSB  = 3;
	localparam int CTRL_FIX_BIT  = 5;

	// Reset values
	localparam logic [5:0]  CTRL_RST    = 6'h00;
	localparam logic [7:0]  FRAMES_RST  = 8'h01;
	localparam logic [15:0] FIXLEN_RST  = 16'h0000;
	localparam logic [5:0]  SYNCLEN_RST = 6'h10;

	// Channel specific data word fields
	localparam int CSD_IPH_BIT  = 30;
	localparam int CSD_MA_BIT   = 29;
	localparam int CSD_MI_BIT   = 28;
	localparam int CSD_LOCK_LSB = 24;
	localparam int CSD_THRU_BIT = 20;
	localparam int CSD_PACK_BIT = 19;
	localparam int CSD_UNPK_BIT = 18;
	localparam int OFFSET_W     = 18;

	// Intra-packet header layout
	localparam logic [2:0] HDR_LAST_IDX  = 3'd4;
	localparam int         DHDR_LOCK_LSB = 12;

	// Packing geometry
	localparam int          WORD_W      = 16;
	localparam logic [4:0]  WORD_BITS   = 5'd16;
	localparam logic [5:0]  SPLIT_MIN   = 6'd17;
	localparam logic [5:0]  POS_MAX     = 6'h3f;

	// Checksum selections
	localparam logic [1:0] CKS_NONE = 2'b00;
	localparam logic [1:0] CKS_8    = 2'b01;
	localparam logic [1:0] CKS_16   = 2'b10;
	localparam logic [1:0] CKS_32   = 2'b11;

	// One bit from the frame synchronizer with its markers
	typedef struct packed {
		logic valid;
		logic data;
		logic word_end;
		logic minor_start;
		logic major_start;
		logic frame_end;
	} ppf_bit_s;

	// One 16-bit word of the packet stream
	typedef struct packed {
		logic                valid;
		logic [WORD_W-1:0]   data;
		logic                first;
	} ppf_word_s;

	// Framer states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE   = 8'b0000_0001,
		ST_CSD_LO = 8'b0000_0010,
		ST_CSD_HI = 8'b0000_0100,
		ST_HDR    = 8'b0000_1000,
		ST_DATA   = 8'b0001_0000,
		ST_FILL   = 8'b0010_0000,
		ST_CKS    = 8'b0100_0000,
		ST_END    = 8'b1000_0000
	} ppf_state_e;

	// Number of trailer words a checksum selection takes
	function automatic logic [1:0] cks_words(input logic [1:0] sel);
		case (sel)
			CKS_8:   cks_words = 2'd1;
			CKS_16:  cks_words = 2'd1;
			CKS_32:  cks_words = 2'd2;
			default: cks_words = 2'd0;
		endcase
	endfunction : cks_words

endpackage : ppf_pkg

`default_nettype wire

// ---- rtl/ppf_bit_packer.sv ----
// Bit assembler turning synchronizer bits into 16-bit packet words
`default_nettype none

module ppf_bit_packer (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Mode
	input  wire logic                      en,
	input  wire logic                      thru,
	input  wire logic                      unpk,
	input  wire logic [5:0]                sync_len,
	// Incoming bits
	input  wire ppf_pkg::ppf_bit_s         bit_in,
	// Word out, one deep
	input  wire logic                      out_ready,
	output logic                           out_valid,
	output logic [ppf_pkg::WORD_W-1:0]     out_data
);

	logic [ppf_pkg::WORD_W-1:0] acc_ff;
	logic [4:0]                 cnt_ff;
	logic [5:0]                 pos_ff;
	logic                       take;
	logic [ppf_pkg::WORD_W-1:0] nxt_acc;
	logic [4:0]                 nxt_cnt;
	logic [5:0]                 idx;
	logic                       split;
	logic                       flush;

	// Bit position in the minor frame and flush decision
	always_comb begin
		take    = en & bit_in.valid;
		nxt_acc = {acc_ff[ppf_pkg::WORD_W-2:0], bit_in.data};
		nxt_cnt = cnt_ff + 5'd1;
		idx     = bit_in.minor_start ? 6'd0 : pos_ff;
		// First sync half gets the floor, so an odd extra bit falls to the second
		split   = unpk & (sync_len >= ppf_pkg::SPLIT_MIN)
			& ((idx + 6'd1) == {1'b0, sync_len[5:1]});
		flush   = take & ((nxt_cnt == ppf_pkg::WORD_BITS)
			| (~thru & bit_in.frame_end)
			| (~thru & unpk & (bit_in.word_end | split)));
	end

	// Shift register; cleared on flush so short words leave zero pad on top
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= 16'h0000;
			cnt_ff <= 5'h00;
		end else if (flush) begin
			acc_ff <= 16'h0000;
			cnt_ff <= 5'h00;
		end else if (take) begin
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
		end
	end

	// Frame bit position, saturating past the longest sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_ff <= 6'h00;
		end else if (take) begin
			pos_ff <= (idx == ppf_pkg::POS_MAX) ? idx : idx + 6'd1;
		end
	end

	// Holding word; a new flush wins over the take of the old one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= 16'h0000;
		end else if (flush) begin
			out_valid <= 1'b1;
			out_data  <= nxt_acc;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : ppf_bit_packer

`default_nettype wire

// ---- rtl/ppf_checksum.sv ----
// Data checksum accumulator over the 16-bit packet stream
`default_nettype none

module ppf_checksum (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Control
	input  wire logic                  clr,
	input  wire logic                  add,
	input  wire logic [1:0]            sel,
	input  wire logic [15:0]           word,
	// Running sum
	output logic [31:0]                sum
);

	logic        phase_ff;
	logic [31:0] addend;

	// Addend per selection; long words take the low half first
	always_comb begin
		case (sel)
			ppf_pkg::CKS_8:  addend = {24'h000000, word[7:0]} + {24'h000000, word[15:8]};
			ppf_pkg::CKS_16: addend = {16'h0000, word};
			ppf_pkg::CKS_32: addend = phase_ff ? {word, 16'h0000} : {16'h0000, word};
			default:         addend = 32'h00000000;
		endcase
	end

	// Carries past the top bit simply fall off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum      <= 32'h00000000;
			phase_ff <= 1'b0;
		end else if (clr) begin
			sum      <= 32'h00000000;
			phase_ff <= 1'b0;
		end else if (add) begin
			sum      <= sum + addend;
			phase_ff <= ~phase_ff;
		end
	end

endmodule : ppf_checksum

`default_nettype wire

// ---- sim/ppf_framer_monitor.sv ----
// Port checker for the PCM packet framer
`default_nettype none

module ppf_framer_checker (
	// Clock and reset
	input wire logic               CLK,
	input wire logic               RST_N,
	// Lock input
	input wire logic [3:0]         SYNCHRONIZER_LOCK_STATE,
	// Packet stream
	input wire ppf_pkg::ppf_word_s PKT_OUT,
	input wire logic               PKT_END,
	// Register port
	input wire logic [7:0]         REG_ADDR,
	input wire logic [31:0]        REG_WDATA,
	input wire logic               REG_WR,
	input wire logic               REG_RD,
	input wire logic [31:0]        REG_RDATA
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] wcnt_ff;

	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// Words of the current packet, restarted by the first word
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wcnt_ff <= 16'h0;
		end else if (PKT_OUT.valid) begin
			wcnt_ff <= PKT_OUT.first ? 16'h1 : wcnt_ff + 16'h1;
		end
	end

	even_len_a: assert property (PKT_END |-> !wcnt_ff[0] && wcnt_ff != 16'h0)
		else $error("packet length is not a four-byte multiple");
	csd_pair_a: assert property (PKT_OUT.first |=> PKT_OUT.valid && !PKT_OUT.first)
		else $error("channel word halves not back to back");
	mode_onehot_a: assert property (PKT_OUT.first |=> $onehot(PKT_OUT.data[4:2])
		&& PKT_OUT.data[7:5] == 3'h0 && !PKT_OUT.data[15]) else $error("bad mode field");
	hdr_flag_a: assert property (PKT_OUT.first |=> PKT_OUT.data[14] != PKT_OUT.data[4])
		else $error("header flag disagrees with mode");
	thru_csd_a: assert property (PKT_OUT.first ##1 PKT_OUT.data[4] |->
		PKT_OUT.data == 16'h0010 && $past(PKT_OUT.data) == 16'h0) else $error("bad raw csd");
	lock_field_a: assert property (PKT_OUT.first ##1 !PKT_OUT.data[4] |->
		PKT_OUT.data[11:8] == $past(SYNCHRONIZER_LOCK_STATE, 3)) else $error("bad lock field");
	hdr_burst_a: assert property (PKT_OUT.first ##1 !PKT_OUT.data[4] |=>
		PKT_OUT.valid [*5]) else $error("frame header words not contiguous");
	end_pulse_a: assert property (PKT_END |-> !PKT_OUT.valid && $past(PKT_OUT.valid) ##1 !PKT_END)
		else $error("end pulse misplaced");
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read answer");
	unmapped_rd_a: assert property (REG_RD && !(REG_ADDR inside {8'h00, 8'h04, 8'h08, 8'h0c,
		8'h10}) |=> REG_RDATA == 32'h0) else $error("unmapped read not zero");
	ctrl_back_a: assert property (REG_WR && REG_ADDR == 8'h00 ##1 !REG_WR ##1 REG_RD
		&& REG_ADDR == 8'h00 |=> REG_RDATA == {26'h0, $past(REG_WDATA[5:0], 3)})
		else $error("control readback differs");
endmodule : ppf_framer_checker

bind ppf_framer ppf_framer_checker chk (.CLK(CLK), .RST_N(RST_N),
	.SYNCHRONIZER_LOCK_STATE(SYNCHRONIZER_LOCK_STATE), .PKT_OUT(PKT_OUT), .PKT_END(PKT_END),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA));

`default_nettype wire

// ---- sim/ppf_sync_model.sv ----
// Frame synchronizer model feeding marked bits to the framer
`default_nettype none

module ppf_sync_model (
	// Clock
	input  wire logic         clk,
	// Bit stream
	output ppf_pkg::ppf_bit_s bit_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet line at start
	initial begin
		bit_o = '0;
	end

	// Bits msb first, 17 cycles apart; idle data shows the inverse of the last bit
	// Marks: [0] word end, [1] minor start, [2] major start, [3] frame end
	task automatic send(input logic [31:0] v, input int n, input logic [3:0] mk);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			bit_o <= '{1'b1, v[i], mk[0] && i == 0, mk[1] && i == n - 1,
				mk[2] && i == n - 1, mk[3] && i == 0};
			@(posedge clk);
			bit_o <= '{1'b0, ~v[i], 1'b0, 1'b0, 1'b0, 1'b0};
			repeat (15) @(posedge clk);
		end
	endtask : send
endmodule : ppf_sync_model

`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the PCM packet framer
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic               CLK = 1'b0;
	logic               RST_N = 1'b0;
	ppf_pkg::ppf_bit_s  bit_in;
	logic [3:0]         lock = 4'hf;
	logic [63:0]        tstamp = 64'h1111_2222_3333_4444;
	ppf_pkg::ppf_word_s pkt;
	logic               pkt_end;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0;
	logic [31:0]        rdata;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	int                 n_mismatch = 0;
	int                 n_checks = 0;
	int                 n_cyc = 0;
	int                 n_end = 0;
	logic [15:0]        got[$];
	logic [15:0]        exp_q[$];

	ppf_framer dut (.CLK(CLK), .RST_N(RST_N), .BIT_IN(bit_in), .SYNCHRONIZER_LOCK_STATE(lock),
		.TIME_STAMP(tstamp), .PKT_OUT(pkt), .PKT_END(pkt_end), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
	ppf_sync_model src (.clk(CLK), .bit_o(bit_in));

	// 4 ns clock
	always #2 CLK = ~CLK;

	// Word collector and hang guard
	always @(posedge CLK) begin
		if (pkt.valid === 1'b1) got.push_back(pkt.data);
		if (pkt_end === 1'b1) n_end++;
		n_cyc++;
		if (n_cyc == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		n_checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, a, e);
		end
	endtask : chk

	// Gap after each write keeps the strobe from being driven twice in one step
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge CLK);
		wr <= 1'b0;
		@(posedge CLK);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge CLK);
		rd <= 1'b0;
		// Look while the answer stands, then hand back on a clock edge
		#1 chk(rdata, e);
		@(posedge CLK);
	endtask : reg_rd

	// Filler and checksum appended to the expected words
	task automatic seal(input logic [1:0] sel, input int fix);
		int          nc;
		logic [7:0]  s8;
		logic [15:0] s16;
		logic [31:0] s32;
		nc = (sel == 2'b11) ? 2 : (sel == 2'b00) ? 0 : 1;
		while ((exp_q.size() + nc) % 2 != 0 || exp_q.size() + nc < fix) exp_q.push_back(16'h0);
		s8 = 8'h0;
		s16 = 16'h0;
		s32 = 32'h0;
		foreach (exp_q[i]) begin
			s8 += exp_q[i][15:8] + exp_q[i][7:0];
			s16 += exp_q[i];
			s32 += (i % 2 == 0) ? {16'h0, exp_q[i]} : {exp_q[i], 16'h0};
		end
		case (sel)
			2'b01: exp_q.push_back({s8, 8'h00});
			2'b10: exp_q.push_back(s16);
			2'b11: begin
				exp_q.push_back(s32[15:0]);
				exp_q.push_back(s32[31:16]);
			end
			default: ;
		endcase
	endtask : seal

	// Waits for one packet end, then compares every word
	task automatic judge(input int k, input string name);
		for (int c = 0; c < 600 && n_end == k; c++) @(posedge CLK);
		repeat (4) @(posedge CLK);
		chk(32'(n_end), 32'(k + 1));
		chk(32'(got.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) if (i < got.size()) chk({16'h0, got[i]}, {16'h0, exp_q[i]});
		$display("%s done", name);
	endtask : judge

	task automatic t_regs();
		reg_rd(8'h00, 32'h0);
		reg_rd(8'h04, 32'h1);
		reg_rd(8'h08, 32'h0);
		reg_rd(8'h0c, 32'h10);
		reg_rd(8'h14, 32'h0);
		reg_wr(8'h00, 32'h2a);
		reg_rd(8'h00, 32'h2a);
		reg_wr(8'h00, 32'h0);
		$display("registers done");
	endtask : t_regs

	// Unpacked, 24-bit sync split 12/12, short words padded, 16-bit sum
	task automatic t_unpacked();
		int k;
		reg_wr(8'h0c, 32'h18);
		reg_wr(8'h00, 32'h15);
		got.delete();
		k = n_end;
		src.send(32'hfaf320, 24, 4'b0111);
		src.send(32'habc, 12, 4'b0001);
		src.send(32'h1234, 16, 4'b0001);
		src.send(32'h5e, 8, 4'b1001);
		exp_q = '{16'h0000, 16'h7f04, 16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'hf000,
			16'h0faf, 16'h0320, 16'h0abc, 16'h1234, 16'h005e};
		seal(2'b10, 0);
		judge(k, "unpacked");
	endtask : t_unpacked

	// Packed, two frames, fixed length of 24 words, 32-bit sum, no major start
	task automatic t_packed();
		int k;
		reg_wr(8'h0c, 32'h10);
		reg_wr(8'h08, 32'h18);
		reg_wr(8'h04, 32'h2);
		reg_wr(8'h00, 32'h39);
		lock <= 4'hb;
		got.delete();
		k = n_end;
		repeat (2) begin
			src.send(32'heb90, 16, 4'b0011);
			src.send(32'habcde, 20, 4'b1001);
		end
		exp_q = '{16'h0000, 16'h5b08};
		repeat (2) exp_q = {exp_q, 16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'hb000,
			16'heb90, 16'habcd, 16'h000e};
		seal(2'b11, 24);
		judge(k, "packed");
	endtask : t_packed

	// Throughput, two raw words, 8-bit sum
	task automatic t_thru();
		int k;
		reg_wr(8'h04, 32'h2);
		reg_wr(8'h00, 32'h0b);
		got.delete();
		k = n_end;
		src.send(32'h13579bdf, 32, 4'b0000);
		exp_q = '{16'h0000, 16'h0010, 16'h1357, 16'h9bdf};
		seal(2'b01, 0);
		judge(k, "throughput");
		reg_wr(8'h00, 32'h0);
		// Idle state code beside a count of three packets
		reg_rd(8'h10, 32'h0001_0003);
	endtask : t_thru

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		t_regs();
		t_unpacked();
		t_packed();
		t_thru();
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
